// *** pkg/crt_cfg.svh ***
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH
`define CRT_ADDR_W 14
`define CRT_COL_W 8
`define CRT_NUM_REGS 20
`define CRT_REG_RESET 8'h00
`define CRT_IDX_HTOTAL 5'h00
`define CRT_IDX_HDISP 5'h01
`define CRT_IDX_HSPOS 5'h02
`define CRT_IDX_SWIDTH 5'h03
`define CRT_IDX_VTOTAL 5'h04
`define CRT_IDX_VADJ 5'h05
`define CRT_IDX_VDISP 5'h06
`define CRT_IDX_VSPOS 5'h07
`define CRT_IDX_MODE 5'h08
`define CRT_IDX_SCANL 5'h09
`define CRT_IDX_CSTART 5'h0A
`define CRT_IDX_CEND 5'h0B
`define CRT_IDX_DSTART_H 5'h0C
`define CRT_IDX_DSTART_L 5'h0D
`define CRT_IDX_CPOS_H 5'h0E
`define CRT_IDX_CPOS_L 5'h0F
`define CRT_IDX_PEN_H 5'h10
`define CRT_IDX_PEN_L 5'h11
`define CRT_IDX_UPD_H 5'h12
`define CRT_IDX_UPD_L 5'h13
`define CRT_IDX_DUMMY 5'h1F
`define CRT_MASK_8 8'hFF
`define CRT_MASK_7 8'h7F
`define CRT_MASK_6 8'h3F
`define CRT_MASK_5 8'h1F
`define CRT_MODE_ROWCOL 2
`define CRT_MODE_TRANSP 3
`define CRT_MODE_DE_SKEW 4
`define CRT_MODE_CUR_SKEW 5
`define CRT_MODE_STROBE 6
`define CRT_CUR_MODE_LO 5
`define CRT_CUR_MODE_HI 6
`define CRT_CUR_NONE 2'h1
`define CRT_CUR_BLINK16 2'h2
`define CRT_CUR_BLINK32 2'h3
`define CRT_BLINK16_BIT 3
`define CRT_BLINK32_BIT 4
`define CRT_VS_ZERO_LINES 5'h10
`define CRT_SYNC_ZERO_NONE 5'h00
`endif

// *** pkg/crt_pkg.sv ***
`include "crt_cfg.svh"
package crt_pkg;
   typedef enum logic [2:0] {
      CRT_UPD_IDLE = 3'b001,
      CRT_UPD_WAIT = 3'b010,
      CRT_UPD_STROBE = 3'b100
   } crt_upd_state_t;
   typedef logic [`CRT_ADDR_W-1:0] crt_addr_t;

   // Column offset within a line; row/column keeps the row field fixed
   function automatic crt_addr_t crt_addr_add(input crt_addr_t base, input logic [7:0] n, input logic rowcol);
      crt_addr_t r;
      r = rowcol ? {base[`CRT_ADDR_W-1:`CRT_COL_W], 8'(base[`CRT_COL_W-1:0] + n)}
                 : crt_addr_t'(base + crt_addr_t'(n));
      return r;
   endfunction : crt_addr_add
endpackage : crt_pkg

// *** logic/crt_pin_sync.sv ***
`timescale 1ns/100ps
module crt_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] stable,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   // Second and third stage must agree before a change counts
   wire [WIDTH-1:0] agree = ~(s2 ^ s3);
   wire [WIDTH-1:0] next_stable = (agree & s3) | (~agree & stable);

   generate
      if (WIDTH < 1) begin : g_chk
         $error("crt_pin_sync: WIDTH must be at least 1");
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         stable <= '0;
         rise <= '0;
         fall <= '0;
      end else if (ce) begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         stable <= next_stable;
         rise <= next_stable & ~stable;
         fall <= ~next_stable & stable;
      end
   end
endmodule : crt_pin_sync

// *** logic/crt_sync_pulse.sv ***
`timescale 1ns/100ps
module crt_sync_pulse (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic clear,
   input wire logic step,
   input wire logic start,
   input wire logic [3:0] width,
   input wire logic [4:0] zero_len,
   output logic active
);
   logic [4:0] remain;
   // A zero width field stands for zero_len steps
   wire [4:0] load_len = (width == 4'h0) ? zero_len : {1'b0, width};

   assign active = (remain != 5'h00);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         remain <= 5'h00;
      end else if (ce) begin
         if (clear) begin
            remain <= 5'h00;
         end else if (step) begin
            if (start) begin
               remain <= load_len;
            end else if (remain != 5'h00) begin
               remain <= remain - 5'h01;
            end
         end
      end
   end
endmodule : crt_sync_pulse

// *** logic/crt_raster_timing.sv ***
// Operation
// - Raster reset low: counters zero, raster outputs low; bus outputs keep working
// - Scan restarts from origin on reset release
// - Frame scan begins at display start address
// - Binary mode: addresses step linearly
// - Row/column: low byte column, high row
// - Row address counts scan lines per row
// - Transparent mode: row MSB becomes update strobe
// - Five-bit pointer selects register on bus
// - Status byte bits 7..5 read with select low
// - Line wraps after horizontal total plus one
// - Horizontal displayed sets active characters
// - Horizontal sync starts at programmed position
// - Vertical width zero means sixteen lines
// - Vertical total sets rows per frame
// - Adjust adds scan lines after last row
// - Vertical displayed sets active rows
// - Vertical sync starts at programmed row
// - Mode bit 2 selects address format
// - Dummy write requests update, completion sets status
`timescale 1ns/100ps
`include "crt_cfg.svh"
module crt_raster_timing
   import crt_pkg::*;
#(
   parameter int ADDR_W = `CRT_ADDR_W
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic bus_clk,
   input wire logic chip_select_n,
   input wire logic read_not_write,
   input wire logic reg_select,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic char_clk,
   input wire logic raster_reset_n,
   input wire logic pen_strobe,
   output logic [ADDR_W-1:0] refresh_addr,
   output logic [4:0] scan_row_addr,
   output logic hsync,
   output logic vsync,
   output logic display_enable,
   output logic cursor
);
   generate
      if (ADDR_W != `CRT_ADDR_W) begin : g_chk
         $error("crt_raster_timing: address width must match register pairs");
      end
   endgenerate

   // Pin synchronisation, all from outside the core clock
   logic [14:0] pin_stable;
   logic [14:0] pin_rise;
   logic [14:0] pin_fall;
   crt_pin_sync #(.WIDTH(15)) u_pins (
      .clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .pin({pen_strobe, raster_reset_n, char_clk, read_not_write, reg_select, chip_select_n, bus_clk, data_in}),
      .stable(pin_stable),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   wire [7:0] bus_data = pin_stable[7:0];
   wire bus_clk_s = pin_stable[8];
   wire bus_fall = pin_fall[8];
   wire cs_n_s = pin_stable[9];
   wire rs_s = pin_stable[10];
   wire rnw_s = pin_stable[11];
   wire char_tick = pin_rise[12];
   wire raster_run = pin_stable[13];
   wire pen_rise = pin_rise[14];
   // Bus cycle fields held while the bus clock is high; data is gone soon after the fall
   logic held_sel;
   logic held_rs;
   logic held_rnw;
   logic [7:0] held_data;
   logic [4:0] reg_pointer;
   logic [7:0] regs [0:`CRT_NUM_REGS-1];
   logic upd_ready;
   logic pen_full;
   logic upd_pending;
   crt_upd_state_t upd_state;
   crt_upd_state_t next_upd_state;

   wire cycle_end = bus_fall & held_sel;
   wire ptr_write = cycle_end & ~held_rs & ~held_rnw;
   wire reg_write = cycle_end & held_rs & ~held_rnw;
   wire reg_read = cycle_end & held_rs & held_rnw;
   wire dummy_write = reg_write & (reg_pointer == `CRT_IDX_DUMMY);
   wire pen_read = reg_read & ((reg_pointer == `CRT_IDX_PEN_H) | (reg_pointer == `CRT_IDX_PEN_L));
   wire upd_done = (upd_state == CRT_UPD_STROBE) & char_tick & raster_run;

   function automatic logic [7:0] reg_mask(input logic [4:0] idx);
      logic [7:0] m;
      m = `CRT_MASK_8;
      case (idx)
         `CRT_IDX_VTOTAL, `CRT_IDX_VDISP, `CRT_IDX_VSPOS, `CRT_IDX_CSTART: m = `CRT_MASK_7;
         `CRT_IDX_VADJ, `CRT_IDX_SCANL, `CRT_IDX_CEND: m = `CRT_MASK_5;
         `CRT_IDX_DSTART_H, `CRT_IDX_CPOS_H, `CRT_IDX_PEN_H, `CRT_IDX_UPD_H: m = `CRT_MASK_6;
         default: m = `CRT_MASK_8;
      endcase
      return m;
   endfunction : reg_mask

   function automatic logic writable(input logic [4:0] idx);
      return (idx < 5'(`CRT_NUM_REGS)) & (idx != `CRT_IDX_PEN_H) & (idx != `CRT_IDX_PEN_L);
   endfunction : writable

   // Programmed values
   wire [7:0] htotal = regs[`CRT_IDX_HTOTAL];
   wire [7:0] hdisp = regs[`CRT_IDX_HDISP];
   wire [7:0] hspos = regs[`CRT_IDX_HSPOS];
   wire [7:0] swidth = regs[`CRT_IDX_SWIDTH];
   wire [6:0] vtotal = regs[`CRT_IDX_VTOTAL][6:0];
   wire [4:0] vadj = regs[`CRT_IDX_VADJ][4:0];
   wire [6:0] vdisp = regs[`CRT_IDX_VDISP][6:0];
   wire [6:0] vspos = regs[`CRT_IDX_VSPOS][6:0];
   wire [7:0] mode = regs[`CRT_IDX_MODE];
   wire [4:0] scan_last = regs[`CRT_IDX_SCANL][4:0];
   wire [4:0] cur_first = regs[`CRT_IDX_CSTART][4:0];
   wire [1:0] cur_mode = regs[`CRT_IDX_CSTART][`CRT_CUR_MODE_HI:`CRT_CUR_MODE_LO];
   wire [4:0] cur_last = regs[`CRT_IDX_CEND][4:0];
   wire [ADDR_W-1:0] disp_start = {regs[`CRT_IDX_DSTART_H][5:0], regs[`CRT_IDX_DSTART_L]};
   wire [ADDR_W-1:0] cur_pos = {regs[`CRT_IDX_CPOS_H][5:0], regs[`CRT_IDX_CPOS_L]};
   wire [ADDR_W-1:0] upd_addr = {regs[`CRT_IDX_UPD_H][5:0], regs[`CRT_IDX_UPD_L]};
   wire rowcol = mode[`CRT_MODE_ROWCOL];
   wire transparent = mode[`CRT_MODE_TRANSP] & mode[`CRT_MODE_STROBE];

   // Raster counters
   logic [7:0] h_count;
   logic [4:0] line_count;
   logic [6:0] row_count;
   logic in_adjust;
   logic [ADDR_W-1:0] row_start;
   logic [4:0] frame_count;

   wire h_end = (h_count == htotal);
   wire row_end = ~in_adjust & (line_count == scan_last);
   wire last_row = (row_count == vtotal);
   wire adj_end = in_adjust & (line_count == 5'(vadj - 5'h01));
   wire frame_end = (row_end & last_row & (vadj == 5'h00)) | adj_end;
   wire enter_adjust = row_end & last_row & (vadj != 5'h00);
   wire line_tick = char_tick & h_end;

   wire [7:0] next_h_count = h_end ? 8'h00 : 8'(h_count + 8'h01);
   wire [4:0] next_line_count = (frame_end | row_end) ? 5'h00 : 5'(line_count + 5'h01);
   wire [6:0] next_row_count = frame_end ? 7'h00 : (row_end ? 7'(row_count + 7'h01) : row_count);
   wire next_in_adjust = ~frame_end & (in_adjust | enter_adjust);
   wire [ADDR_W-1:0] row_step = rowcol ? {6'(row_start[ADDR_W-1:`CRT_COL_W] + 6'h01), row_start[`CRT_COL_W-1:0]}
                                       : crt_addr_add(row_start, hdisp, 1'b0);
   wire [ADDR_W-1:0] next_row_start = frame_end ? disp_start : (row_end ? row_step : row_start);

   // Character position on the refresh address lines
   wire [ADDR_W-1:0] scan_addr = crt_addr_add(row_start, h_count, rowcol);
   wire de_now = (h_count < hdisp) & (row_count < vdisp) & ~in_adjust;
   wire blink_on = (cur_mode == `CRT_CUR_BLINK16) ? frame_count[`CRT_BLINK16_BIT]
                 : (cur_mode == `CRT_CUR_BLINK32) ? frame_count[`CRT_BLINK32_BIT]
                 : (cur_mode != `CRT_CUR_NONE);
   wire cur_now = de_now & blink_on & (scan_addr == cur_pos) & (line_count >= cur_first) & (line_count <= cur_last);

   // Sync generators
   wire hs_active;
   wire vs_active;
   wire hs_start = (next_h_count == hspos);
   wire vs_start = (next_row_count == vspos) & (next_line_count == 5'h00) & ~next_in_adjust;

   crt_sync_pulse u_hsync (
      .clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .clear(~raster_run),
      .step(char_tick),
      .start(hs_start),
      .width(swidth[3:0]),
      .zero_len(`CRT_SYNC_ZERO_NONE),
      .active(hs_active)
   );

   crt_sync_pulse u_vsync (
      .clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .clear(~raster_run),
      .step(line_tick),
      .start(vs_start),
      .width(swidth[7:4]),
      .zero_len(`CRT_VS_ZERO_LINES),
      .active(vs_active)
   );

   // Output selection
   wire strobe_now = (upd_state == CRT_UPD_STROBE);
   wire [ADDR_W-1:0] next_refresh_addr = strobe_now ? upd_addr : scan_addr;
   wire next_row_msb = transparent ? strobe_now : line_count[4];
   wire [7:0] status_byte = {upd_ready, pen_full, vs_active, 5'h00};
   wire [7:0] reg_rd_data = (reg_pointer == `CRT_IDX_CPOS_H) ? {2'b00, cur_pos[ADDR_W-1:`CRT_COL_W]}
                          : (reg_pointer == `CRT_IDX_CPOS_L) ? cur_pos[`CRT_COL_W-1:0]
                          : (reg_pointer == `CRT_IDX_PEN_H) ? regs[`CRT_IDX_PEN_H]
                          : (reg_pointer == `CRT_IDX_PEN_L) ? regs[`CRT_IDX_PEN_L]
                          : 8'h00;
   wire [7:0] next_data_out = rs_s ? reg_rd_data : status_byte;
   wire next_data_oe = bus_clk_s & ~cs_n_s & rnw_s;
   wire [ADDR_W-1:0] next_upd_addr = crt_addr_add(upd_addr, 8'h01, rowcol);

   // Update request sequencing
   always_comb begin
      next_upd_state = upd_state;
      case (upd_state)
         CRT_UPD_IDLE: begin
            if (upd_pending) begin
               next_upd_state = CRT_UPD_WAIT;
            end
         end
         CRT_UPD_WAIT: begin
            if (char_tick & transparent & ~de_now) begin
               next_upd_state = CRT_UPD_STROBE;
            end
         end
         CRT_UPD_STROBE: begin
            if (char_tick) begin
               next_upd_state = CRT_UPD_IDLE;
            end
         end
         default: next_upd_state = CRT_UPD_IDLE;
      endcase
   end

   // Bus side: register file, pointer and status
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         held_sel <= 1'b0;
         held_rs <= 1'b0;
         held_rnw <= 1'b1;
         held_data <= 8'h00;
      end else if (ce & bus_clk_s) begin
         held_sel <= ~cs_n_s;
         held_rs <= rs_s;
         held_rnw <= rnw_s;
         held_data <= bus_data;
      end
   end

   // Control registers survive raster reset; only rstn clears them
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_pointer <= 5'h00;
         for (int i = 0; i < `CRT_NUM_REGS; i++) begin
            regs[i] <= `CRT_REG_RESET;
         end
      end else if (ce) begin
         if (ptr_write) begin
            reg_pointer <= held_data[4:0];
         end
         if (reg_write & writable(reg_pointer)) begin
            regs[reg_pointer] <= held_data & reg_mask(reg_pointer);
         end
         if (upd_done) begin
            regs[`CRT_IDX_UPD_H] <= {2'b00, next_upd_addr[ADDR_W-1:`CRT_COL_W]};
            regs[`CRT_IDX_UPD_L] <= next_upd_addr[`CRT_COL_W-1:0];
         end
         if (pen_rise) begin
            regs[`CRT_IDX_PEN_H] <= {2'b00, scan_addr[ADDR_W-1:`CRT_COL_W]};
            regs[`CRT_IDX_PEN_L] <= scan_addr[`CRT_COL_W-1:0];
         end
      end
   end

   // Set wins over clear on both sticky flags
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         upd_ready <= 1'b0;
         pen_full <= 1'b0;
         upd_pending <= 1'b0;
      end else if (ce) begin
         upd_ready <= upd_done | (upd_ready & ~dummy_write);
         pen_full <= pen_rise | (pen_full & ~pen_read);
         upd_pending <= dummy_write | (upd_pending & ~upd_done);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         upd_state <= CRT_UPD_IDLE;
      end else if (ce) begin
         upd_state <= raster_run ? next_upd_state : CRT_UPD_IDLE;
      end
   end

   // Raster counters, frozen and zeroed while raster reset is low; row_start reloads disp_start
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         h_count <= 8'h00;
         line_count <= 5'h00;
         row_count <= 7'h00;
         in_adjust <= 1'b0;
         row_start <= '0;
         frame_count <= 5'h00;
      end else if (ce) begin
         if (!raster_run) begin
            h_count <= 8'h00;
            line_count <= 5'h00;
            row_count <= 7'h00;
            in_adjust <= 1'b0;
            row_start <= disp_start;
            frame_count <= 5'h00;
         end else if (char_tick) begin
            h_count <= next_h_count;
            if (h_end) begin
               line_count <= next_line_count;
               row_count <= next_row_count;
               in_adjust <= next_in_adjust;
               row_start <= next_row_start;
               if (frame_end) begin
                  frame_count <= 5'(frame_count + 5'h01);
               end
            end
         end
      end
   end

   // Registered outputs; the skew stages give the one-character delay options
   logic de_q;
   logic cur_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         refresh_addr <= '0;
         scan_row_addr <= 5'h00;
         hsync <= 1'b0;
         vsync <= 1'b0;
         display_enable <= 1'b0;
         cursor <= 1'b0;
         de_q <= 1'b0;
         cur_q <= 1'b0;
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else if (ce) begin
         data_out <= next_data_out;
         data_oe <= next_data_oe;
         if (!raster_run) begin
            refresh_addr <= '0;
            scan_row_addr <= 5'h00;
            hsync <= 1'b0;
            vsync <= 1'b0;
            display_enable <= 1'b0;
            cursor <= 1'b0;
            de_q <= 1'b0;
            cur_q <= 1'b0;
         end else begin
            refresh_addr <= next_refresh_addr;
            scan_row_addr <= {next_row_msb, line_count[3:0]};
            hsync <= hs_active;
            vsync <= vs_active;
            if (char_tick) begin
               de_q <= de_now;
               cur_q <= cur_now;
            end
            display_enable <= mode[`CRT_MODE_DE_SKEW] ? de_q : de_now;
            cursor <= mode[`CRT_MODE_CUR_SKEW] ? cur_q : cur_now;
         end
      end
   end
endmodule : crt_raster_timing

// *** sim/crt_raster_timing_checker.sv ***
`timescale 1ns/100ps
module crt_raster_timing_checker #(
   parameter int ADDR_W = 14
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic chip_select_n,
   input wire logic read_not_write,
   input wire logic char_clk,
   input wire logic raster_reset_n,
   input wire logic data_oe,
   input wire logic [ADDR_W-1:0] refresh_addr,
   input wire logic [4:0] scan_row_addr,
   input wire logic hsync,
   input wire logic vsync,
   input wire logic display_enable,
   input wire logic cursor
);
   logic [3:0] rl_cnt, rh_cnt, cs_cnt, wr_cnt;
   function automatic logic [3:0] sat(input logic [3:0] c);
      return (c == 4'hF) ? c : c + 4'h1;
   endfunction : sat
   // Saturating run lengths; the pins pass a synchroniser, so every check waits them out
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rl_cnt <= 4'h0;
         rh_cnt <= 4'h0;
         cs_cnt <= 4'h0;
         wr_cnt <= 4'h0;
      end else begin
         rl_cnt <= raster_reset_n ? 4'h0 : sat(rl_cnt);
         rh_cnt <= raster_reset_n ? sat(rh_cnt) : 4'h0;
         cs_cnt <= chip_select_n ? sat(cs_cnt) : 4'h0;
         wr_cnt <= read_not_write ? 4'h0 : sat(wr_cnt);
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   rst_addr_zero_a: assert property (rl_cnt >= 4'h8 |-> refresh_addr == '0)
      else $error("refresh address not zero in raster reset");
   rst_row_zero_a: assert property (rl_cnt >= 4'h8 |-> scan_row_addr == 5'h00)
      else $error("row address not zero in raster reset");
   rst_sync_low_a: assert property (rl_cnt >= 4'h8 |-> !hsync && !vsync)
      else $error("sync active in raster reset");
   rst_video_low_a: assert property (rl_cnt >= 4'h8 |-> !display_enable && !cursor)
      else $error("video active in raster reset");
   // Ticks come only from rising character clock edges, so nothing moves while it is low
   tick_addr_hold_a: assert property (!char_clk && rh_cnt >= 4'hA |-> $stable(refresh_addr))
      else $error("address moved without a character tick");
   tick_sync_hold_a: assert property (!char_clk && rh_cnt >= 4'hA |->
      $stable(hsync) && $stable(vsync) && $stable(scan_row_addr))
      else $error("timing moved without a character tick");
   bus_idle_quiet_a: assert property (cs_cnt >= 4'hC |-> !data_oe)
      else $error("data driven while not selected");
   write_quiet_a: assert property (wr_cnt >= 4'hC |-> !data_oe)
      else $error("data driven during a write");
   cover property ($rose(hsync));
   cover property ($rose(data_oe));
   cover property (rl_cnt == 4'hF);
endmodule : crt_raster_timing_checker
bind crt_raster_timing crt_raster_timing_checker #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .rstn, .chip_select_n,
   .read_not_write, .char_clk, .raster_reset_n, .data_oe, .refresh_addr, .scan_row_addr, .hsync, .vsync,
   .display_enable, .cursor);

// *** sim/crt_far_side.sv ***
`timescale 1ns/100ps
module crt_far_side #(
   parameter int HALF = 8
) (
   input wire logic core_clk,
   input wire logic hold_req,
   output logic char_clk,
   output logic raster_reset_n
);
   int n = 0;
   int lows = 0;
   initial begin
      char_clk = 1'b0;
      raster_reset_n = 1'b0;
   end
   // Free-running character clock; reset kept low two whole character periods
   // Release lands on the falling half so it never meets a character tick
   always @(negedge core_clk) begin
      n = (n + 1) % HALF;
      if (n == 0) begin
         char_clk = ~char_clk;
         if (char_clk) begin
            lows = hold_req ? 0 : ((lows < 2) ? lows + 1 : lows);
         end else begin
            raster_reset_n = (lows >= 2);
         end
      end
   end
endmodule : crt_far_side

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic bus_clk = 1'b0;
   logic chip_select_n = 1'b1;
   logic read_not_write = 1'b1;
   logic reg_select = 1'b0;
   logic [7:0] data_in = 8'h00;
   logic hold_req = 1'b0;
   logic [7:0] data_out, q;
   logic data_oe, char_clk, raster_reset_n, hsync, vsync, display_enable, cursor;
   logic [13:0] refresh_addr;
   logic [4:0] scan_row_addr;
   wire logic [3:0] mon = {scan_row_addr[4], display_enable, vsync, hsync};
   int fail_count = 0;
   int num_checks = 0;
   int cyc_n = 0;
   int t0, t1, t2, i;
   logic [15:0] tbl [12] = '{16'h0009, 16'h0106, 16'h0207, 16'h0322, 16'h0402, 16'h0501,
      16'h0602, 16'h0702, 16'h0800, 16'h0901, 16'h0C01, 16'h0D00};
   crt_raster_timing DUT (.core_clk, .rstn, .ce(1'b1), .bus_clk, .chip_select_n, .read_not_write,
      .reg_select, .data_in, .data_out, .data_oe, .char_clk, .raster_reset_n, .pen_strobe(1'b0),
      .refresh_addr, .scan_row_addr, .hsync, .vsync, .display_enable, .cursor);
   crt_far_side u_far (.core_clk, .hold_req, .char_clk, .raster_reset_n);
   initial forever #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) cyc_n++;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc
   // One bus cycle; select held ten cycles past the falling edge for the synchroniser
   task automatic bus(input logic rs, input logic rnw, input logic [7:0] d, output logic [7:0] r);
      @(negedge core_clk);
      {bus_clk, chip_select_n, reg_select, read_not_write, data_in} = {1'b1, 1'b0, rs, rnw, d};
      cyc(10);
      r = data_out;
      bus_clk = 1'b0;
      cyc(10);
      chip_select_n = 1'b1;
      read_not_write = 1'b1;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      bus(1'b0, 1'b0, idx, q);
      bus(1'b1, 1'b0, v, q);
   endtask : wr
   task automatic rd(input logic [7:0] idx, output logic [7:0] r);
      bus(1'b0, 1'b0, idx, q);
      bus(1'b1, 1'b1, 8'h00, r);
   endtask : rd
   task automatic wait_on(input int s, input logic lvl);
      int k;
      for (k = 0; k < 8000 && mon[s] !== lvl; k++) @(negedge core_clk);
      if (mon[s] !== lvl) begin
         fail_count++;
         $display("unexpected at %0t: wait ran out", $time);
         end_sim();
      end
   endtask : wait_on
   task automatic rise(input int s);
      wait_on(s, 1'b0);
      wait_on(s, 1'b1);
   endtask : rise
   task automatic t_raster_reset();
      hold_req = 1'b1;
      cyc(80);
      chk({refresh_addr, scan_row_addr, hsync, vsync, display_enable, cursor}, 16'h0000);
      rd(8'h0F, q);
      chk(q, 8'h5A);
      hold_req = 1'b0;
      rise(2);
      cyc(2);
      chk({vsync, scan_row_addr, refresh_addr}, 16'h0100);
   endtask : t_raster_reset
   task automatic t_line();
      rise(2);
      t0 = cyc_n;
      wait_on(2, 1'b0);
      chk(cyc_n - t0, 96);
      rise(0);
      t1 = cyc_n;
      chk(t1 - t0, 112);
      wait_on(0, 1'b0);
      chk(cyc_n - t1, 32);
      rise(0);
      chk(cyc_n - t1, 160);
   endtask : t_line
   task automatic t_frame(input logic rc);
      wr(8'h08, rc ? 8'h04 : 8'h00);
      rise(1);
      wait_on(1, 1'b0);
      for (i = 0; i < 4; i++) begin
         rise(2);
         if (i == 0) t0 = cyc_n;
         cyc(2);
         chk(refresh_addr, (i < 2) ? 16'h0100 : (rc ? 16'h0200 : 16'h0106));
         chk(scan_row_addr, i % 2);
         cyc(16);
         chk(refresh_addr[7:0], (i < 2) ? 8'h01 : (rc ? 8'h01 : 8'h07));
      end
      rise(1);
      chk(cyc_n - t0, 640);
   endtask : t_frame
   task automatic t_vs(input int w, input int p);
      rise(1);
      t0 = cyc_n;
      bus(1'b0, 1'b1, 8'h00, q);
      chk({q[5], q[4:0]}, 6'h20);
      wait_on(1, 1'b0);
      chk(cyc_n - t0, w);
      rise(1);
      chk(cyc_n - t0, p);
   endtask : t_vs
   task automatic t_update();
      wr(8'h08, 8'h48);
      wr(8'h12, 8'h01);
      wr(8'h13, 8'h23);
      for (i = 0; i < 2; i++) begin
         rise(2);
         wr(8'h1F, 8'h00);
         rise(3);
         cyc(1);
         chk(refresh_addr, 16'h0123 + i);
         wait_on(3, 1'b0);
         bus(1'b0, 1'b1, 8'h00, q);
         chk(q[7], 1'b1);
      end
      wr(8'h08, 8'h00);
   endtask : t_update
   initial begin
      cyc(2);
      rstn = 1'b1;
      cyc(4);
      foreach (tbl[j]) wr(tbl[j][15:8], tbl[j][7:0]);
      wr(8'h0F, 8'h5A);
      rd(8'h0F, q);
      chk(q, 8'h5A);
      rd(8'h00, q);
      chk(q, 8'h00);
      t_raster_reset();
      t_line();
      t_frame(1'b0);
      t_frame(1'b1);
      t_vs(320, 1120);
      t_update();
      // Upper width zero needs a frame long enough to hold sixteen lines
      wr(8'h05, 8'h1F);
      wr(8'h03, 8'h02);
      rise(1);
      t_vs(2560, 5920);
      end_sim();
   end
endmodule : tb
